/* File: pfa_pkg.sv */
package pfa_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RI_OFFSET = 8'h04;
    localparam logic [7:0] OFF_SI_OFFSET = 8'h08;
    localparam logic [7:0] OFF_SO_OFFSET = 8'h0c;
    localparam logic [7:0] OFF_PHASE = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    // control word fields
    localparam int CTRL_W = 6;
    localparam int CTRL_EDGE_BIT = 0;
    localparam int CTRL_WIDE_BIT = 1;
    localparam int CTRL_RO_LSB = 2;
    localparam int CTRL_SO_LSB = 4;

    // reset values
    localparam logic [5:0] RST_CTRL = 6'h00;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [1:0] RST_PHASE = 2'h0;

    // packed configuration carried into the link domain
    localparam int CFG_W = 32;
    localparam int CFG_RI_LSB = 6;
    localparam int CFG_SI_LSB = 14;
    localparam int CFG_SO_LSB = 22;
    localparam int CFG_PH_LSB = 30;

    // output path selection
    typedef enum logic [1:0] {
        ROUTE_NORMAL = 2'b00,
        ROUTE_SAME = 2'b01,
        ROUTE_CROSS = 2'b10
    } pfa_route_e;

    // ------------------------------------------------------------------
    // frame timing
    // ------------------------------------------------------------------
    localparam int FRAME_TIME_NS = 125000;
    localparam int SYS_CLK_KHZ = 8192;
    localparam int FRAME_CYCLES = FRAME_TIME_NS / 1000 * SYS_CLK_KHZ / 1000;
    localparam int POS_W = 10;
    localparam int BITS_PER_FRAME = FRAME_CYCLES / 4;
    localparam logic [9:0] POS_LAST = 10'(FRAME_CYCLES - 1);
    localparam logic [1:0] PH_LAUNCH = 2'h0;
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [10:0] MISS_LIMIT = 11'(2 * FRAME_CYCLES - 1);
    localparam logic [2:0] MDIV_RST = 3'h0;

endpackage : pfa_pkg

/* File: pfa_sync3.sv */
`timescale 1ns/100ps

// three-stage synchroniser; a change is passed on once stages two and
// three agree, so a level caught mid-transition is not taken early
module pfa_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                out_reg[i] <= 1'b0;
            end else if (s2_reg[i] == s3_reg[i]) begin
                out_reg[i] <= s3_reg[i];
            end
        end
    end

    assign dout = out_reg;

endmodule : pfa_sync3

/* File: pfa_align.sv */
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps

//
// Contract
// - three frame offsets place ri, si, so frames
// - generated sync replaces absent external sync
// - programmable bit phase valid at sync
// - alignment refers to ideal falling-edge bit start
// - inputs sampled at start of bit phase 2
// - outputs launched at start of bit phase 0
// - receive out lags receive in one frame
// - edge select 0: falling edge samples, syncs
// - edge select 1: rising samples, next falling syncs
// - sync active low, 2048k PCM, 8192k clock
// - sync out width one or two clocks
// - derive half, system, eighth rate clocks
// - bypass routes between all PCM ins and outs
//
module pfa_align
    import pfa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic system_bit_clock,
    input wire logic master_clock,
    input wire logic frame_sync_in_n,
    output logic frame_sync_out_n,
    input wire logic receive_pcm_in,
    input wire logic send_pcm_in,
    output logic receive_pcm_out,
    output logic send_pcm_out,
    output logic half_rate_clock,
    output logic derived_system_clock,
    output logic eighth_rate_clock_out
);

    // ------------------------------------------------------------------
    // apb slave, zero wait state: pready rises in the first access cycle
    // ------------------------------------------------------------------
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [7:0] ri_off_reg;
    logic [7:0] si_off_reg;
    logic [7:0] so_off_reg;
    logic [1:0] ph_reg;
    logic [2:0] stat_s;
    logic busy;
    logic dirty_reg;

    wire apb_setup = psel & ~penable;
    wire apb_access = psel & penable & pready_reg;
    wire hit_ctrl = paddr == OFF_CTRL;
    wire hit_ri = paddr == OFF_RI_OFFSET;
    wire hit_si = paddr == OFF_SI_OFFSET;
    wire hit_so = paddr == OFF_SO_OFFSET;
    wire hit_ph = paddr == OFF_PHASE;
    wire hit_stat = paddr == OFF_STATUS;
    wire hit_any = hit_ctrl | hit_ri | hit_si | hit_so | hit_ph | hit_stat;
    wire wr_en = apb_access & pwrite & hit_any;
    wire cfg_wr = wr_en & ~hit_stat;

    wire [31:0] rd_mux =
        hit_ctrl ? {26'h0, ctrl_reg} :
        hit_ri ? {24'h0, ri_off_reg} :
        hit_si ? {24'h0, si_off_reg} :
        hit_so ? {24'h0, so_off_reg} :
        hit_ph ? {30'h0, ph_reg} :
        hit_stat ? {29'h0, busy | dirty_reg, stat_s[2:1]} : 32'h0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup & ~hit_any;
            prdata_reg <= (apb_setup & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= RST_CTRL;
            ri_off_reg <= RST_OFFSET;
            si_off_reg <= RST_OFFSET;
            so_off_reg <= RST_OFFSET;
            ph_reg <= RST_PHASE;
        end else if (wr_en) begin
            if (hit_ctrl) ctrl_reg <= pwdata[CTRL_W-1:0];
            if (hit_ri) ri_off_reg <= pwdata[7:0];
            if (hit_si) si_off_reg <= pwdata[7:0];
            if (hit_so) so_off_reg <= pwdata[7:0];
            if (hit_ph) ph_reg <= pwdata[1:0];
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------------
    // configuration handover: word held still while the toggle crosses
    // ------------------------------------------------------------------
    logic [CFG_W-1:0] xfer_reg;
    logic req_tgl_reg;
    logic req_s;
    logic lk_ack_reg;
    logic lk_present_reg;
    logic lk_aligned_reg;

    wire [CFG_W-1:0] cfg_pack = {ph_reg, so_off_reg, si_off_reg, ri_off_reg,
                                 ctrl_reg};
    wire cfg_launch = dirty_reg & ~busy;
    assign busy = req_tgl_reg != stat_s[0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dirty_reg <= 1'b0;
            req_tgl_reg <= 1'b0;
            xfer_reg <= '0;
        end else begin
            // a write in the launch cycle keeps dirty set: set wins
            dirty_reg <= cfg_wr | (dirty_reg & ~cfg_launch);
            if (cfg_launch) begin
                xfer_reg <= cfg_pack;
                req_tgl_reg <= ~req_tgl_reg;
            end
        end
    end

    pfa_sync3 #(.W(3)) u_stat_sync (
        .clk(ref_clk),
        .rst(rst),
        .din({lk_aligned_reg, lk_present_reg, lk_ack_reg}),
        .dout(stat_s)
    );

    pfa_sync3 #(.W(1)) u_req_sync (
        .clk(system_bit_clock),
        .rst(rst),
        .din(req_tgl_reg),
        .dout(req_s)
    );

    // ------------------------------------------------------------------
    // link domain: all pcm timing runs on falling system clock edges
    // ------------------------------------------------------------------
    logic [CFG_W-1:0] lk_cfg_reg;

    always_ff @(negedge system_bit_clock or posedge rst) begin
        if (rst) begin
            lk_cfg_reg <= '0;
            lk_ack_reg <= 1'b0;
        end else if (req_s != lk_ack_reg) begin
            lk_cfg_reg <= xfer_reg;
            lk_ack_reg <= req_s;
        end
    end

    wire lk_edge_sel = lk_cfg_reg[CTRL_EDGE_BIT];
    wire lk_wide = lk_cfg_reg[CTRL_WIDE_BIT];
    wire [1:0] lk_ro_route = lk_cfg_reg[CTRL_RO_LSB +: 2];
    wire [1:0] lk_so_route = lk_cfg_reg[CTRL_SO_LSB +: 2];
    wire [1:0] lk_phase = lk_cfg_reg[CFG_PH_LSB +: 2];
    logic [7:0] lk_off [3];
    assign lk_off[0] = lk_cfg_reg[CFG_RI_LSB +: 8];
    assign lk_off[1] = lk_cfg_reg[CFG_SI_LSB +: 8];
    assign lk_off[2] = lk_cfg_reg[CFG_SO_LSB +: 8];

    // ------------------------------------------------------------------
    // frame sync detection and generation
    // ------------------------------------------------------------------
    logic sync_rise_reg;
    logic ext_prev_reg;
    logic [POS_W-1:0] gen_reg;
    logic [10:0] miss_reg;
    logic sync_out_reg;

    // rising-edge sample; acted on at the next falling edge
    always_ff @(posedge system_bit_clock or posedge rst) begin
        if (rst) sync_rise_reg <= 1'b1;
        else sync_rise_reg <= frame_sync_in_n;
    end

    wire ext_act = lk_edge_sel ? ~sync_rise_reg : ~frame_sync_in_n;
    wire ext_evt = ext_act & ~ext_prev_reg;
    wire gen_wrap = gen_reg == POS_LAST;
    // the generated pulse stands in only while no external sync arrives
    wire sync_pt = ext_evt | (~lk_present_reg & gen_wrap);
    wire [POS_W-1:0] gen_next = ext_evt ? '0 : POS_W'(gen_reg + 10'h001);
    wire sync_out_next = ~((gen_next == '0) |
                           (lk_wide & (gen_next == 10'h001)));

    always_ff @(negedge system_bit_clock or posedge rst) begin
        if (rst) begin
            ext_prev_reg <= 1'b0;
            gen_reg <= '0;
            miss_reg <= '0;
            lk_present_reg <= 1'b0;
            lk_aligned_reg <= 1'b0;
            sync_out_reg <= 1'b1;
        end else begin
            ext_prev_reg <= ext_act;
            gen_reg <= gen_next;
            sync_out_reg <= sync_out_next;
            miss_reg <= ext_evt ? '0 : 11'(miss_reg + 11'h001);
            if (ext_evt) lk_present_reg <= 1'b1;
            else if (miss_reg == MISS_LIMIT) lk_present_reg <= 1'b0;
            if (sync_pt) lk_aligned_reg <= 1'b1;
        end
    end

    assign frame_sync_out_n = sync_out_reg;

    // ------------------------------------------------------------------
    // per-stream position counters {bit of frame, bit phase}
    // index 0: receive in (and receive out), 1: send in, 2: send out
    // ------------------------------------------------------------------
    logic [POS_W-1:0] pos_reg [3];
    logic [POS_W-1:0] pos_next [3];

    for (genvar g = 0; g < 3; g++) begin : g_pos
        // the loaded value is the ideal phase that begins at this edge
        assign pos_next[g] = sync_pt ? {lk_off[g], lk_phase} :
                             POS_W'(pos_reg[g] + 10'h001);
        always_ff @(negedge system_bit_clock or posedge rst) begin
            if (rst) pos_reg[g] <= '0;
            else pos_reg[g] <= pos_next[g];
        end
    end

    wire ri_sample = pos_next[0][1:0] == PH_SAMPLE;
    wire ri_launch = pos_next[0][1:0] == PH_LAUNCH;
    wire si_sample = pos_next[1][1:0] == PH_SAMPLE;
    wire so_launch = pos_next[2][1:0] == PH_LAUNCH;
    // bit index counts from bit 7 of slot 0, so MSB-first order is kept
    wire [7:0] ri_idx = pos_next[0][POS_W-1:2];
    wire [7:0] si_idx = pos_next[1][POS_W-1:2];
    wire [7:0] so_idx = pos_next[2][POS_W-1:2];

    // ------------------------------------------------------------------
    // frame stores: read at phase 0 before the same slot is rewritten at
    // phase 2, giving exactly one frame of delay on the receive path
    // ------------------------------------------------------------------
    logic rx_mem [BITS_PER_FRAME];
    logic tx_mem [BITS_PER_FRAME];
    logic ro_reg;
    logic so_reg;

    always_ff @(negedge system_bit_clock) begin
        if (ri_sample) rx_mem[ri_idx] <= receive_pcm_in;
        if (si_sample) tx_mem[si_idx] <= send_pcm_in;
    end

    // bypass paths are retimed each falling edge; outputs stay registered
    wire ro_next =
        (lk_ro_route == ROUTE_SAME) ? receive_pcm_in :
        (lk_ro_route == ROUTE_CROSS) ? send_pcm_in :
        ri_launch ? rx_mem[ri_idx] : ro_reg;
    wire so_next =
        (lk_so_route == ROUTE_SAME) ? send_pcm_in :
        (lk_so_route == ROUTE_CROSS) ? receive_pcm_in :
        so_launch ? tx_mem[so_idx] : so_reg;

    always_ff @(negedge system_bit_clock or posedge rst) begin
        if (rst) begin
            ro_reg <= 1'b1;
            so_reg <= 1'b1;
        end else begin
            ro_reg <= ro_next;
            so_reg <= so_next;
        end
    end

    assign receive_pcm_out = ro_reg;
    assign send_pcm_out = so_reg;

    // ------------------------------------------------------------------
    // derived clocks from the master clock: /2, /4, /8
    // ------------------------------------------------------------------
    logic [2:0] mdiv_reg;

    always_ff @(posedge master_clock or posedge rst) begin
        if (rst) mdiv_reg <= MDIV_RST;
        else mdiv_reg <= 3'(mdiv_reg + 3'h1);
    end

    assign half_rate_clock = mdiv_reg[0];
    assign derived_system_clock = mdiv_reg[1];
    assign eighth_rate_clock_out = mdiv_reg[2];

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_apb_ready;
        @(posedge ref_clk) disable iff (rst)
        apb_setup |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("pready not one cycle after setup");

    property p_apb_err;
        @(posedge ref_clk) disable iff (rst)
        apb_setup && !hit_any |=> pready && pslverr && prdata == 32'h0;
    endproperty
    a_apb_err: assert property (p_apb_err)
        else $error("unmapped access not flagged");

    sequence s_quiet2;
        !sync_pt [*2];
    endsequence

    property p_sample_phase;
        @(negedge system_bit_clock) disable iff (rst)
        ri_launch ##1 s_quiet2 |-> ri_sample;
    endproperty
    a_sample_phase: assert property (p_sample_phase)
        else $error("input not sampled two phases after launch");

    property p_launch_phase;
        @(negedge system_bit_clock) disable iff (rst)
        lk_so_route == ROUTE_NORMAL && $changed(send_pcm_out)
            |-> $past(so_launch);
    endproperty
    a_launch_phase: assert property (p_launch_phase)
        else $error("send output changed outside phase 0");

    property p_offset_load;
        @(negedge system_bit_clock) disable iff (rst)
        sync_pt |=> pos_reg[1] == {$past(lk_off[1]), $past(lk_phase)};
    endproperty
    a_offset_load: assert property (p_offset_load)
        else $error("send in position not loaded at sync");

    property p_sync_width;
        @(negedge system_bit_clock) disable iff (rst)
        $fell(frame_sync_out_n) && !ext_evt |->
            if (lk_wide) ##1 !frame_sync_out_n ##1 frame_sync_out_n
            else ##1 frame_sync_out_n;
    endproperty
    a_sync_width: assert property (p_sync_width)
        else $error("sync out pulse width wrong");

    property p_internal_ref;
        @(negedge system_bit_clock) disable iff (rst)
        !lk_present_reg && gen_wrap |=> pos_reg[0][1:0] == $past(lk_phase);
    endproperty
    a_internal_ref: assert property (p_internal_ref)
        else $error("generated sync did not realign counters");

    property p_bypass_cross;
        @(negedge system_bit_clock) disable iff (rst)
        lk_ro_route == ROUTE_CROSS |=> receive_pcm_out == $past(send_pcm_in);
    endproperty
    a_bypass_cross: assert property (p_bypass_cross)
        else $error("cross bypass to receive out broken");

    property p_eighth_clk;
        @(posedge master_clock) disable iff (rst)
        $rose(eighth_rate_clock_out) |-> eighth_rate_clock_out [*4]
            ##1 !eighth_rate_clock_out;
    endproperty
    a_eighth_clk: assert property (p_eighth_clk)
        else $error("eighth rate clock high time wrong");

endmodule : pfa_align

/* File: pfa_highway_model.sv */
`timescale 1ns/100ps

// far-side highway: free-running link clock, frame sync and msb-first
// samples on both pcm inputs; data moves on a rising edge so that every
// falling edge of the device sees settled data
module pfa_highway_model (
    input wire logic sync_en,
    input wire logic edge_mode,
    output logic system_bit_clock,
    output logic frame_sync_in_n,
    output logic receive_pcm_in,
    output logic send_pcm_in,
    output logic [9:0] pos
);
    logic [7:0] frame;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [2:0] bit_sel;
    logic fs_fall;
    logic fs_rise;

    assign bit_sel = 3'h7 - pos[4:2];
    assign rx_byte = ({3'h0, pos[9:5]} * 8'h1d) ^ frame;
    assign tx_byte = rx_byte ^ 8'ha5;
    // one driver for the sync pin; the mode picks which edge moved it
    assign frame_sync_in_n = edge_mode ? fs_fall : fs_rise;

    initial begin
        system_bit_clock = 1'b1;
        fs_fall = 1'b1;
        fs_rise = 1'b1;
        receive_pcm_in = 1'b1;
        send_pcm_in = 1'b1;
        pos = 10'h3ff;
        frame = 8'h00;
    end

    always #6 system_bit_clock = ~system_bit_clock;

    always @(negedge system_bit_clock) begin
        pos <= pos + 10'h001;
        if (pos == 10'h3ff) frame <= frame + 8'h01;
        // low across the rising edge that precedes position 0
        fs_fall <= !(sync_en && pos == 10'h3fe);
    end

    always @(posedge system_bit_clock) begin
        fs_rise <= !(sync_en && pos == 10'h3ff);
        if (pos[1:0] == 2'h0) begin
            receive_pcm_in <= rx_byte[bit_sel];
            send_pcm_in <= tx_byte[bit_sel];
        end
    end
endmodule : pfa_highway_model

/* File: pfa_align_test.sv */
`timescale 1ns/100ps

`define PFA_CHECK(got, exp) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module pfa_align_test
    import pfa_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic master_clock = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic sync_en = 1'b0;
    logic edge_mode = 1'b0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire frame_sync_out_n;
    wire receive_pcm_out;
    wire send_pcm_out;
    wire half_rate_clock;
    wire derived_system_clock;
    wire eighth_rate_clock_out;
    wire sclk;
    wire sync_n;
    wire rx_in;
    wire tx_in;
    wire [9:0] pos;
    wire [2:0] dclk;
    int failures = 0;
    int checked = 0;
    int ncnt = 0;
    int lag_idx;
    logic hist [0:2047];
    logic [1:0] chk_mode = 2'h0;
    logic [1:0] cur_phase = 2'h0;
    logic [1:0] dph;
    logic [5:0] cur_ctrl = 6'h00;
    logic [31:0] rdata;
    logic rerr;

    always #5 ref_clk = ~ref_clk;
    always #15.3 master_clock = ~master_clock;

    assign dclk = {eighth_rate_clock_out, derived_system_clock,
                   half_rate_clock};
    assign dph = pos[1:0] + cur_phase;
    assign lag_idx = (ncnt - 1023 - int'(dph)) % 2048;

    pfa_align pfa_align_inst (
        .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .system_bit_clock(sclk), .master_clock(master_clock),
        .frame_sync_in_n(sync_n), .frame_sync_out_n(frame_sync_out_n),
        .receive_pcm_in(rx_in), .send_pcm_in(tx_in),
        .receive_pcm_out(receive_pcm_out), .send_pcm_out(send_pcm_out),
        .half_rate_clock(half_rate_clock),
        .derived_system_clock(derived_system_clock),
        .eighth_rate_clock_out(eighth_rate_clock_out)
    );

    pfa_highway_model pfa_highway_model_inst (
        .sync_en(sync_en), .edge_mode(edge_mode), .system_bit_clock(sclk),
        .frame_sync_in_n(sync_n), .receive_pcm_in(rx_in),
        .send_pcm_in(tx_in), .pos(pos)
    );

    // ------------------------------------------------------------
    // stream checks
    // ------------------------------------------------------------
    always @(negedge sclk) begin
        hist[ncnt % 2048] = rx_in;
        ncnt = ncnt + 1;
    end

    // outputs move on the falling edge, so look half a bit clock later
    always @(posedge sclk) begin
        if (chk_mode == 2'h1) begin
            `PFA_CHECK(receive_pcm_out, hist[lag_idx])
        end
        if (chk_mode == 2'h2 && pos[1:0] == 2'h2) begin
            `PFA_CHECK(receive_pcm_out, cur_ctrl[3] ? tx_in : rx_in)
            `PFA_CHECK(send_pcm_out, cur_ctrl[5] ? rx_in : tx_in)
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            complete_run();
        end
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic err);
        apb(a, 1'b0, 32'h0);
        `PFA_CHECK(rdata, exp)
        `PFA_CHECK(rerr, err)
    endtask : rd_chk

    // the link side takes new settings some link clocks after a write
    task automatic settle(input int frames);
        int n;
        n = 0;
        do begin
            apb(OFF_STATUS, 1'b0, 32'h0);
            n++;
        end while (rdata[2] !== 1'b0 && n < 64);
        if (rdata[2] !== 1'b0) begin
            failures++;
            complete_run();
        end
        repeat (frames * 1024) @(posedge sclk);
    endtask : settle

    task automatic div_check(input int sel, input logic [3:0] half);
        logic v;
        logic [3:0] n;
        int t;
        @(negedge master_clock);
        v = dclk[sel];
        t = 0;
        n = 4'h0;
        while (dclk[sel] === v && t < 20) begin
            @(negedge master_clock);
            t++;
        end
        v = dclk[sel];
        while (dclk[sel] === v && t < 40) begin
            @(negedge master_clock);
            t++;
            n++;
        end
        `PFA_CHECK(n, half)
    endtask : div_check

    task automatic sync_width(input logic [10:0] exp);
        logic [10:0] lows;
        lows = 11'h000;
        repeat (1024) begin
            @(posedge sclk);
            if (frame_sync_out_n === 1'b0) lows++;
        end
        `PFA_CHECK(lows, exp)
    endtask : sync_width

    task automatic run_case(input logic [5:0] ctrl, input logic [7:0] ofs,
                            input logic [1:0] ph);
        apb(OFF_CTRL, 1'b1, {26'h3ffffff, ctrl});
        apb(OFF_RI_OFFSET, 1'b1, {24'hffffff, ofs});
        apb(OFF_PHASE, 1'b1, {30'h3fffffff, ph});
        cur_ctrl = ctrl;
        cur_phase = ph;
        @(posedge sclk);
        edge_mode <= ctrl[0];
        rd_chk(OFF_CTRL, {26'h0, ctrl}, 1'b0);
        rd_chk(OFF_RI_OFFSET, {24'h0, ofs}, 1'b0);
        rd_chk(OFF_PHASE, {30'h0, ph}, 1'b0);
        settle(2);
        rd_chk(OFF_STATUS, 32'h3, 1'b0);
        chk_mode = (ctrl[5:2] == 4'h0) ? 2'h1 : 2'h2;
        repeat (1024) @(posedge sclk);
        chk_mode = 2'h0;
        sync_width(ctrl[1] ? 11'h002 : 11'h001);
    endtask : run_case

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        #1000000;
        failures++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(OFF_CTRL, 32'h0, 1'b0);
        rd_chk(OFF_PHASE, 32'h0, 1'b0);
        for (int i = 1; i < 4; i++) begin
            rd_chk(8'(4 * i), 32'h0, 1'b0);
            apb(8'(4 * i), 1'b1, 32'hffffff00 | 32'(i * 17));
            rd_chk(8'(4 * i), 32'(i * 17), 1'b0);
        end
        rd_chk(8'h18, 32'h0, 1'b1);
        apb(8'h18, 1'b1, 32'hffffffff);
        `PFA_CHECK(rerr, 1'b1)
        for (int i = 0; i < 3; i++) div_check(i, 4'(1 << i));
        // no external sync: the generated pulse must take over
        settle(4);
        rd_chk(OFF_STATUS, 32'h2, 1'b0);
        sync_width(11'h001);
        @(posedge sclk);
        sync_en <= 1'b1;
        run_case(6'h00, 8'h00, 2'h0);
        run_case(6'h02, 8'h05, 2'h1);
        run_case(6'h01, 8'h1f, 2'h3);
        run_case(6'h14, 8'h00, 2'h2);
        run_case(6'h29, 8'h00, 2'h0);
        complete_run();
    end
endmodule : pfa_align_test
